// ---- rtl/sixteen_bit_timer_counter.sv ----
// Sixteen bit timer/counter with prescaler, edge synchroniser and overflow flag.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module sixteen_bit_timer_counter
   import timer_one_pkg::*;
#(
   parameter int PRESCALE_BITS = 3
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic sleep,
   input wire logic [1:0] special_event,
   input wire logic osc_in_pin_in,
   output logic osc_in_pin_out,
   output logic osc_in_pin_oe,
   input wire logic osc_out_pin_in,
   output logic osc_out_pin_out,
   output logic osc_out_pin_oe,
   output logic osc_power,
   output logic overflow_irq,
   output logic time_base_valid,
   output logic [15:0] time_base
);
   initial begin
      if (PRESCALE_BITS < 3) begin
         $error("PRESCALE_BITS must be at least 3");
      end
   end

   function automatic logic [PRESCALE_BITS-1:0] prescale_mask(input logic [1:0] sel);
      logic [PRESCALE_BITS-1:0] m;
      m = '0;
      case (sel)
         2'b00: m = '0;
         2'b01: m[0] = 1'b1;
         2'b10: m[1:0] = 2'b11;
         default: m[2:0] = 3'b111;
      endcase
      return m;
   endfunction : prescale_mask

   bus_req_type req;
   control_type control_ff;
   logic [7:0] count_low_byte_ff;
   logic [7:0] count_high_byte_ff;
   logic overflow_flag_ff;
   logic overflow_irq_enable_ff;
   logic [1:0] port_dir_ff;
   logic [1:0] port_data_ff;
   logic [1:0] phase_ff;
   logic [PRESCALE_BITS-1:0] prescale_ff;
   logic [1:0] osc_in_sync_ff;
   logic [1:0] osc_out_sync_ff;
   logic ext_prev_ff;
   arm_state_type arm_ff;
   logic [7:0] rdata_ff;
   logic ext_level;
   logic ext_rise;
   logic ext_fall;
   logic counter_mode;
   logic async_mode;
   logic raw_tick;
   logic prescale_tick;
   logic inc_allowed;
   logic inc;
   logic [15:0] count;
   logic [15:0] nxt_count;
   logic wrap;
   logic trigger;
   logic write_low;
   logic write_high;

   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
   assign count = {count_high_byte_ff, count_low_byte_ff};
   assign counter_mode = control_ff.clock_source_select;
   assign async_mode = counter_mode && control_ff.sync_bypass;

   always_ff @(posedge mclk) begin
      osc_in_sync_ff <= {osc_in_sync_ff[0], osc_in_pin_in};
      osc_out_sync_ff <= {osc_out_sync_ff[0], osc_out_pin_in};
   end

   assign ext_level = control_ff.osc_enable ? osc_in_sync_ff[1] : osc_out_sync_ff[1];

   always_ff @(posedge mclk) begin
      if (rst) begin
         ext_prev_ff <= 1'b0;
      end else begin
         ext_prev_ff <= ext_level;
      end
   end

   assign ext_rise = ext_level && !ext_prev_ff;
   assign ext_fall = !ext_level && ext_prev_ff;

   always_ff @(posedge mclk) begin
      if (rst) begin
         arm_ff <= arm_off;
      end else begin
         case (arm_ff)
            arm_off: begin
               if (counter_mode && control_ff.count_enable) begin
                  arm_ff <= arm_wait_fall;
               end
            end
            arm_wait_fall: begin
               if (!(counter_mode && control_ff.count_enable)) begin
                  arm_ff <= arm_off;
               end else if (ext_fall) begin
                  arm_ff <= arm_ready;
               end
            end
            arm_ready: begin
               if (!(counter_mode && control_ff.count_enable)) begin
                  arm_ff <= arm_off;
               end
            end
            default: arm_ff <= arm_off;
         endcase
      end
   end

   // Instruction cycle phase: one tick every fourth oscillator clock.
   always_ff @(posedge mclk) begin
      if (rst) begin
         phase_ff <= 2'h0;
      end else begin
         phase_ff <= phase_ff + 2'h1;
      end
   end

   always_comb begin
      if (counter_mode) begin
         raw_tick = ext_rise && arm_ff == arm_ready;
      end else begin
         raw_tick = phase_ff == PHASE_LAST;
      end
   end

   assign prescale_tick = raw_tick && ((prescale_ff & prescale_mask(control_ff.prescale_select))
      == prescale_mask(control_ff.prescale_select));

   // The prescaler sees every qualified edge, also during sleep.
   always_ff @(posedge mclk) begin
      if (rst) begin
         prescale_ff <= '0;
      end else if (!control_ff.count_enable) begin
         prescale_ff <= '0;
      end else if (raw_tick) begin
         if (prescale_tick) begin
            prescale_ff <= '0;
         end else begin
            prescale_ff <= prescale_ff + 1'b1;
         end
      end
   end

   always_comb begin
      if (!control_ff.count_enable) begin
         inc_allowed = 1'b0;
      end else if (!counter_mode) begin
         inc_allowed = !sleep;
      end else if (async_mode) begin
         inc_allowed = 1'b1;
      end else begin
         inc_allowed = !sleep;
      end
   end

   assign inc = prescale_tick && inc_allowed;
   assign nxt_count = count + 16'h0001;
   assign wrap = inc && count == COUNT_MAX;
   assign trigger = |special_event;
   assign write_low = req.wr && req.addr == COUNT_LOW_ADDR;
   assign write_high = req.wr && req.addr == COUNT_HIGH_ADDR;

   // The count pair has no reset term on purpose.
   always_ff @(posedge mclk) begin
      if (write_low || write_high) begin
         if (write_low) begin
            count_low_byte_ff <= req.wdata;
         end
         if (write_high) begin
            count_high_byte_ff <= req.wdata;
         end
      end else if (trigger) begin
         count_low_byte_ff <= COUNT_ZERO[7:0];
         count_high_byte_ff <= COUNT_ZERO[15:8];
      end else if (inc) begin
         count_low_byte_ff <= nxt_count[7:0];
         count_high_byte_ff <= nxt_count[15:8];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         overflow_flag_ff <= 1'b0;
      end else if (wrap && !trigger) begin
         overflow_flag_ff <= 1'b1;
      end else if (req.wr && req.addr == FLAG_REG_ADDR) begin
         overflow_flag_ff <= req.wdata[OVERFLOW_FLAG_POS];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         overflow_irq_enable_ff <= 1'b0;
      end else if (req.wr && req.addr == ENABLE_REG_ADDR) begin
         overflow_irq_enable_ff <= req.wdata[OVERFLOW_IRQ_EN_POS];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         control_ff <= CONTROL_RESET;
      end else if (req.wr && req.addr == CONTROL_ADDR) begin
         control_ff <= req.wdata[5:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         port_dir_ff <= PORT_DIR_RESET;
         port_data_ff <= PORT_DATA_RESET;
      end else begin
         if (req.wr && req.addr == PORT_DIR_ADDR) begin
            port_dir_ff <= req.wdata[1:0];
         end
         if (req.wr && req.addr == PORT_DATA_ADDR) begin
            port_data_ff <= req.wdata[1:0];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata_ff <= 8'h00;
      end else if (req.rd) begin
         case (req.addr)
            CONTROL_ADDR: rdata_ff <= {2'b00, control_ff};
            COUNT_LOW_ADDR: rdata_ff <= count_low_byte_ff;
            COUNT_HIGH_ADDR: rdata_ff <= count_high_byte_ff;
            FLAG_REG_ADDR: rdata_ff <= {7'h00, overflow_flag_ff};
            ENABLE_REG_ADDR: rdata_ff <= {7'h00, overflow_irq_enable_ff};
            PORT_DIR_ADDR: rdata_ff <= {6'h00, port_dir_ff};
            PORT_DATA_ADDR: begin
               if (control_ff.osc_enable) begin
                  rdata_ff <= 8'h00;
               end else begin
                  rdata_ff <= {6'h00, osc_in_sync_ff[1], osc_out_sync_ff[1]};
               end
            end
            default: rdata_ff <= 8'h00;
         endcase
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   assign rdata = rdata_ff;
   assign osc_out_pin_out = port_data_ff[0];
   assign osc_in_pin_out = port_data_ff[1];
   assign osc_out_pin_oe = !control_ff.osc_enable && !port_dir_ff[0];
   assign osc_in_pin_oe = !control_ff.osc_enable && !port_dir_ff[1];
   assign osc_power = control_ff.osc_enable;
   assign overflow_irq = overflow_flag_ff && overflow_irq_enable_ff;
   assign time_base_valid = !async_mode;
   assign time_base = async_mode ? COUNT_ZERO : count;
endmodule : sixteen_bit_timer_counter

// ---- rtl/timer_one_pkg.sv ----
// Shared constants and types for the sixteen bit timer/counter.
package timer_one_pkg;
   localparam logic [7:0] PORT_DATA_ADDR = 8'h07;
   localparam logic [7:0] FLAG_REG_ADDR = 8'h0C;
   localparam logic [7:0] COUNT_LOW_ADDR = 8'h0E;
   localparam logic [7:0] COUNT_HIGH_ADDR = 8'h0F;
   localparam logic [7:0] CONTROL_ADDR = 8'h10;
   localparam logic [7:0] PORT_DIR_ADDR = 8'h87;
   localparam logic [7:0] ENABLE_REG_ADDR = 8'h8C;

   localparam int COUNT_ENABLE_POS = 0;
   localparam int CLOCK_SOURCE_POS = 1;
   localparam int SYNC_BYPASS_POS = 2;
   localparam int OSC_ENABLE_POS = 3;
   localparam int PRESCALE_LSB_POS = 4;
   localparam int OVERFLOW_FLAG_POS = 0;
   localparam int OVERFLOW_IRQ_EN_POS = 0;

   localparam logic [5:0] CONTROL_RESET = 6'h00;
   localparam logic [1:0] PORT_DIR_RESET = 2'h3;
   localparam logic [1:0] PORT_DATA_RESET = 2'h0;
   localparam logic [1:0] PHASE_LAST = 2'h3;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;

   typedef struct packed {
      logic [1:0] prescale_select;
      logic osc_enable;
      logic sync_bypass;
      logic clock_source_select;
      logic count_enable;
   } control_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_type;

   typedef enum logic [1:0] {
      arm_off,
      arm_wait_fall,
      arm_ready
   } arm_state_type;
endpackage : timer_one_pkg

// ---- verif/ext_clock_src.sv ----
// Model of the external clock that drives the two oscillator pins.
`timescale 1ns/1ps
module ext_clock_src #(
   parameter int HALF = 10
) (
   input wire logic mclk,
   input wire logic run,
   input wire logic sel,
   output logic pin_a,
   output logic pin_b
);
   int cnt = 0;
   logic lvl = 1'b0;
   // The clock stands still while run is low; the unselected pin stays low.
   always @(posedge mclk) begin
      if (!run) begin
         cnt <= 0;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         lvl <= !lvl;
      end else begin
         cnt <= cnt + 1;
      end
   end
   assign pin_a = !sel && lvl;
   assign pin_b = sel && lvl;
endmodule : ext_clock_src

// ---- verif/timer_one_sva.sv ----
// Port assertions for the timer/counter.
`timescale 1ns/1ps
module timer_one_sva
   import timer_one_pkg::*;
#(
   parameter int PRESCALE_BITS = 3
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic [1:0] special_event,
   input wire logic osc_in_pin_oe,
   input wire logic osc_out_pin_oe,
   input wire logic osc_power,
   input wire logic overflow_irq,
   input wire logic time_base_valid,
   input wire logic [15:0] time_base
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   sequence s_step;
      !$past(wr) && time_base == $past(time_base) + 16'h0001;
   endsequence
   sequence s_stop;
      wr && addr == CONTROL_ADDR && !wdata[0] ##1 (!wr && special_event == 2'h0) [*4];
   endsequence
   property p_gap;
      s_step |=> (time_base == $past(time_base) || $past(wr) || $past(special_event) != 2'h0) [*3];
   endproperty
   property p_hold; s_stop |-> $stable(time_base); endproperty
   property p_ctrl; rd && addr == CONTROL_ADDR |=> rdata[7:6] == 2'h0; endproperty
   property p_pins; osc_power |-> !osc_in_pin_oe && !osc_out_pin_oe; endproperty
   property p_pin_rd; rd && addr == PORT_DATA_ADDR && osc_power |=> rdata == 8'h00; endproperty
   property p_base; !time_base_valid |-> time_base == COUNT_ZERO; endproperty
   property p_mask; wr && addr == ENABLE_REG_ADDR && !wdata[0] |=> !overflow_irq; endproperty
   property p_trig;
      special_event != 2'h0 && !(wr && (addr == COUNT_LOW_ADDR || addr == COUNT_HIGH_ADDR)) |=>
         time_base == COUNT_ZERO;
   endproperty
   a_gap: assert property (p_gap)
      else $error("count stepped too soon");
   a_hold: assert property (p_hold)
      else $error("count moved while stopped");
   a_ctrl: assert property (p_ctrl)
      else $error("control top bits set");
   a_pins: assert property (p_pins)
      else $error("pin driven with oscillator on");
   a_pin_rd: assert property (p_pin_rd)
      else $error("pin read not zero");
   a_base: assert property (p_base)
      else $error("time base offered");
   a_mask: assert property (p_mask)
      else $error("request not masked");
   a_trig: assert property (p_trig)
      else $error("trigger did not clear");
endmodule : timer_one_sva
bind sixteen_bit_timer_counter timer_one_sva #(.PRESCALE_BITS(PRESCALE_BITS)) sva (.mclk, .rst, .addr,
   .wdata, .wr, .rd, .rdata, .special_event, .osc_in_pin_oe, .osc_out_pin_oe, .osc_power, .overflow_irq,
   .time_base_valid, .time_base);

// ---- verif/sixteen_bit_timer_counter_tb_top.sv ----
// Self-checking testbench for the sixteen bit timer/counter.
`timescale 1ns/1ps
module sixteen_bit_timer_counter_tb_top;
   import timer_one_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic sleep = 1'b0;
   logic [1:0] special_event = 2'h0;
   logic run = 1'b0;
   logic sel = 1'b0;
   logic [7:0] rdata, b0, b1;
   logic [15:0] time_base, v;
   logic pin_a, pin_b, osc_in_pin_out, osc_in_pin_oe, osc_out_pin_out, osc_out_pin_oe;
   logic osc_power, overflow_irq, time_base_valid;
   wire oi = osc_in_pin_oe ? osc_in_pin_out : pin_b;
   wire oo = osc_out_pin_oe ? osc_out_pin_out : pin_a;
   int mismatches = 0;
   int n_compared = 0;
   int n;
   always #20 mclk = !mclk;
   ext_clock_src #(.HALF(10)) src (.mclk, .run, .sel, .pin_a, .pin_b);
   sixteen_bit_timer_counter #(.PRESCALE_BITS(3)) dut (.mclk, .rst, .addr, .wdata, .wr, .rd, .rdata,
      .sleep, .special_event, .osc_in_pin_in(oi), .osc_in_pin_out, .osc_in_pin_oe, .osc_out_pin_in(oo),
      .osc_out_pin_out, .osc_out_pin_oe, .osc_power, .overflow_irq, .time_base_valid, .time_base);
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : test_done
   task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] s);
      n_compared++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, e, s);
      end
   endtask : cmp
   task automatic limit(input int c, input int b);
      if (c >= b) begin
         mismatches++;
         test_done();
      end
   endtask : limit
   task automatic wreg(input logic [7:0] a, input logic [7:0] d, input logic [1:0] se = 2'h0);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      special_event <= se;
      @(posedge mclk);
      wr <= 1'b0;
      special_event <= 2'h0;
      @(negedge mclk);
   endtask : wreg
   task automatic rdv(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      d = rdata;
   endtask : rdv
   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string what);
      logic [7:0] d;
      rdv(a, d);
      cmp(what, e, d);
   endtask : rchk
   // Measures the cycles between the first and second change of the count.
   task automatic gap(output int c);
      logic [15:0] w;
      for (int k = 0; k < 2; k++) begin
         w = time_base;
         c = 0;
         while (time_base === w && c < 400) begin
            @(negedge mclk);
            c++;
         end
         limit(c, 400);
      end
   endtask : gap
   initial begin
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      rchk(CONTROL_ADDR, 8'h00, "control reset");
      wreg(PORT_DIR_ADDR, 8'h00);
      cmp("pins driven", 2'h3, {osc_in_pin_oe, osc_out_pin_oe});
      wreg(CONTROL_ADDR, 8'hFF);
      rchk(CONTROL_ADDR, 8'h3F, "control bits");
      cmp("pins input", 3'h4, {osc_power, osc_in_pin_oe, osc_out_pin_oe});
      rchk(PORT_DATA_ADDR, 8'h00, "pin read");
      wreg(PORT_DIR_ADDR, 8'h03);
      rchk(8'h00, 8'h00, "unmapped");
      wreg(COUNT_LOW_ADDR, 8'h00);
      wreg(COUNT_HIGH_ADDR, 8'h00);
      for (int p = 0; p < 4; p++) begin
         wreg(CONTROL_ADDR, 8'(p * 16 + 1));
         gap(n);
         cmp("tick gap", 16'(4 << p), 16'(n));
      end
      wreg(CONTROL_ADDR, 8'h00);
      wreg(FLAG_REG_ADDR, 8'h00);
      wreg(COUNT_LOW_ADDR, 8'hFE);
      wreg(COUNT_HIGH_ADDR, 8'hFF);
      rchk(FLAG_REG_ADDR, 8'h00, "flag clear");
      wreg(CONTROL_ADDR, 8'h01);
      n = 0;
      while (time_base !== 16'h0000 && n < 40) begin
         @(negedge mclk);
         n++;
      end
      limit(n, 40);
      wreg(CONTROL_ADDR, 8'h00);
      rchk(COUNT_HIGH_ADDR, 8'h00, "wrapped");
      repeat (20) @(posedge mclk);
      rchk(FLAG_REG_ADDR, 8'h01, "flag sticky");
      wreg(ENABLE_REG_ADDR, 8'h01);
      cmp("irq on", 1'b1, overflow_irq);
      wreg(ENABLE_REG_ADDR, 8'h00);
      cmp("irq masked", 1'b0, overflow_irq);
      wreg(FLAG_REG_ADDR, 8'h00);
      wreg(COUNT_LOW_ADDR, 8'h34);
      wreg(8'h00, 8'h00, 2'h1);
      cmp("trigger", 16'h0000, time_base);
      rchk(FLAG_REG_ADDR, 8'h00, "trigger flag");
      wreg(COUNT_LOW_ADDR, 8'h55, 2'h2);
      rchk(COUNT_LOW_ADDR, 8'h55, "write wins");
      run <= 1'b1;
      wreg(CONTROL_ADDR, 8'h03);
      gap(n);
      cmp("pin gap", 16'd20, 16'(n));
      sleep <= 1'b1;
      v = time_base;
      repeat (60) @(negedge mclk);
      cmp("sleep hold", v, time_base);
      wreg(CONTROL_ADDR, 8'h07);
      cmp("base valid", 1'b0, time_base_valid);
      rdv(COUNT_LOW_ADDR, b0);
      repeat (38) @(posedge mclk);
      rdv(COUNT_LOW_ADDR, b1);
      cmp("sleep count", 8'h02, 8'(b1 - b0));
      sleep <= 1'b0;
      sel <= 1'b1;
      wreg(CONTROL_ADDR, 8'h0B);
      gap(n);
      cmp("osc gap", 16'd20, 16'(n));
      test_done();
   end
endmodule : sixteen_bit_timer_counter_tb_top
